// *** rtl/oag_pkg.sv ***
// Package of constants and types for the operand address generator.
package oag_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // Index mode encodings.
  localparam logic [1:0] IDX_ABS       = 2'h0;
  localparam logic [1:0] IDX_PC        = 2'h1;
  localparam logic [1:0] IDX_ACC_TWO   = 2'h2;
  localparam logic [1:0] IDX_ACC_THREE = 2'h3;

  // Displacement size encodings.
  localparam logic [1:0] DSZ_SHORT = 2'h0;
  localparam logic [1:0] DSZ_EXT   = 2'h1;
  localparam logic [1:0] DSZ_LONG  = 2'h2;
  localparam logic [1:0] DSZ_BYTE  = 2'h3;

  // Request kinds.
  localparam logic [1:0] KIND_WORD = 2'h0;
  localparam logic [1:0] KIND_DBL  = 2'h1;
  localparam logic [1:0] KIND_BYTE = 2'h2;
  localparam logic [1:0] KIND_BIT  = 2'h3;

  localparam logic [4:0] MAX_INDIRECT = 5'h0f;

  // Fault codes; zero means none.
  localparam logic [2:0] FLT_NONE  = 3'h0;
  localparam logic [2:0] FLT_PROT  = 3'h1;
  localparam logic [2:0] FLT_NRES  = 3'h2;
  localparam logic [2:0] FLT_PRIV  = 3'h3;
  localparam logic [2:0] FLT_OUTW  = 3'h4;
  localparam logic [2:0] FLT_COMP  = 3'h5;

  // APB register byte offsets.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_EA     = 8'h08;
  localparam logic [7:0] REG_FAULT  = 8'h0c;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  typedef enum logic [1:0] {OAG_IDLE, OAG_WAIT_PTR, OAG_DONE} oag_state_t;

endpackage

// *** rtl/oag_fault_if.sv ***
// Interface between the address datapath and the fault arbiter.
interface oag_fault_if;
  logic       clear;
  logic       prot;
  logic       nres;
  logic       priv;
  logic       outw;
  logic       comp;
  logic [2:0] code;
  logic       privileged;
  logic       valid;
  modport gen (output clear, output prot, output nres, output priv, output outw,
               output comp, input code, input privileged, input valid);
  modport arb (input clear, input prot, input nres, input priv, input outw,
               input comp, output code, output privileged, output valid);
endinterface

// *** rtl/oag_fault_arb.sv ***
// Fault arbiter: latches the first fault of an instruction and its class.
module oag_fault_arb (
  input  wire logic core_clk,
  input  wire logic rst,
  oag_fault_if.arb  flt
);

  logic [2:0] code_r;
  logic [2:0] code_nxt;

  always_comb
  begin
    code_nxt = oag_pkg::FLT_NONE;
    if (flt.prot)
      code_nxt = oag_pkg::FLT_PROT;
    else if (flt.nres)
      code_nxt = oag_pkg::FLT_NRES;
    else if (flt.priv)
      code_nxt = oag_pkg::FLT_PRIV;
    else if (flt.outw)
      code_nxt = oag_pkg::FLT_OUTW;
    else if (flt.comp)
      code_nxt = oag_pkg::FLT_COMP;
  end

  // A fault arriving with the clear still wins, so none is lost.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      code_r <= oag_pkg::FLT_NONE;
    else if (code_r == oag_pkg::FLT_NONE && code_nxt != oag_pkg::FLT_NONE)
      code_r <= code_nxt;
    else if (flt.clear)
      code_r <= (code_nxt != oag_pkg::FLT_NONE) ? code_nxt : oag_pkg::FLT_NONE;
  end

  assign flt.code       = code_r;
  assign flt.valid      = code_r != oag_pkg::FLT_NONE;
  assign flt.privileged = code_r inside {oag_pkg::FLT_PROT, oag_pkg::FLT_NRES,
                                         oag_pkg::FLT_PRIV, oag_pkg::FLT_OUTW};

  a_first_fault_kept: assert property (@(posedge core_clk) disable iff (rst)
    (code_r != oag_pkg::FLT_NONE && !flt.clear) |=> code_r == $past(code_r))
    else $error("latched fault was overwritten");

  a_comp_nonpriv: assert property (@(posedge core_clk) disable iff (rst)
    (code_r == oag_pkg::FLT_NONE && flt.comp && !flt.prot && !flt.nres && !flt.priv &&
     !flt.outw) |=> (flt.valid && !flt.privileged))
    else $error("computation fault classed privileged");

endmodule

// *** rtl/oag_top.sv ***
// Operand address generator with indirect resolution, byte and bit pointers.
module oag_top (
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Decoder request.
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [1:0]  req_kind,
  input  wire logic [1:0]  req_index,
  input  wire logic [1:0]  req_dsize,
  input  wire logic        req_indirect,
  input  wire logic [31:0] req_disp,
  input  wire logic [1:0]  req_pc_words,
  input  wire logic        req_same_ac,
  input  wire logic        req_io,
  input  wire logic        req_prot_op,
  input  wire logic        req_comp_err,
  input  wire logic [31:0] program_counter,
  input  wire logic [31:0] accumulator_two,
  input  wire logic [31:0] accumulator_three,
  input  wire logic [31:0] acc_source,
  input  wire logic [31:0] acc_dest,
  input  wire logic [2:0]  cur_segment,
  input  wire logic        seg_io_valid,
  input  wire logic        next_instr,
  // Address translation unit side.
  output logic             ea_valid,
  output logic [31:0]      ea_addr,
  output logic             ea_byte_sel,
  output logic [3:0]       ea_bit_pos,
  output logic             ea_is_ptr,
  input  wire logic        ptr_valid,
  input  wire logic [31:0] ptr_data,
  input  wire logic        xlat_refused,
  input  wire logic        xlat_nonres,
  output logic             instr_hold,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  oag_fault_if flt ();

  oag_fault_arb u_arb (
    .core_clk (core_clk),
    .rst      (rst),
    .flt      (flt)
  );

  oag_pkg::oag_state_t state_r;
  logic [31:0]         ctrl_r;
  logic [4:0]          depth_r;
  logic [31:0]         ea_addr_r;
  logic                ea_byte_r;
  logic [3:0]          ea_bit_r;
  logic                ea_valid_r;
  logic                ea_ptr_r;
  logic [31:0]         last_ea_r;
  logic [31:0]         prdata_r;
  logic                xlat_en;

  assign xlat_en = ctrl_r[0];

  // Base selection with bit 0 (the MSB) of each base dropped.
  logic [31:0] base;
  always_comb
  begin
    base = '0;
    unique case (req_index)
      oag_pkg::IDX_ABS:       base = '0;
      oag_pkg::IDX_PC:        base = {1'b0, program_counter[30:0]};
      oag_pkg::IDX_ACC_TWO:   base = {1'b0, accumulator_two[30:0]};
      oag_pkg::IDX_ACC_THREE: base = {1'b0, accumulator_three[30:0]};
    endcase
  end

  logic        rel;
  logic [31:0] disp_ext;
  logic [31:0] pc_adj;
  assign rel = req_index != oag_pkg::IDX_ABS;

  // Displacement extension by size and mode.
  always_comb
  begin
    disp_ext = '0;
    unique case (req_dsize)
      oag_pkg::DSZ_SHORT:
        disp_ext = rel ? {{24{req_disp[7]}}, req_disp[7:0]}
                       : {1'b0, cur_segment, 20'h00000, req_disp[7:0]};
      oag_pkg::DSZ_EXT:
        disp_ext = rel ? {{17{req_disp[14]}}, req_disp[14:0]}
                       : {1'b0, cur_segment, 13'h0000, req_disp[14:0]};
      oag_pkg::DSZ_LONG:
        disp_ext = rel ? {req_disp[30], req_disp[30:0]}
                       : {1'b0, req_disp[30:0]};
      oag_pkg::DSZ_BYTE:
        disp_ext = rel ? {{16{req_disp[15]}}, req_disp[15:0]}
                       : {cur_segment, 13'h0000, req_disp[15:0]};
    endcase
  end

  // PC relative with extended or long displacement adds the preceding word count.
  assign pc_adj = (req_index == oag_pkg::IDX_PC &&
                   (req_dsize == oag_pkg::DSZ_EXT || req_dsize == oag_pkg::DSZ_LONG))
                  ? {30'h0, req_pc_words} : 32'h0;

  logic [31:0] word_sum;
  assign word_sum = base + disp_ext + pc_adj;

  // Byte pointer: a base from an accumulator is doubled, then displacement added.
  logic [31:0] byte_ptr;
  always_comb
  begin
    if (req_dsize == oag_pkg::DSZ_LONG)
      byte_ptr = {base[30:0], 1'b0} + req_disp;
    else
      byte_ptr = {base[30:0], 1'b0} + disp_ext;
  end

  // Bit pointer: source gives base (the segment when req_same_ac), destination the word offset and bit.
  logic [31:0] bit_base;
  logic [31:0] bit_word;
  assign bit_base = req_same_ac ? {1'b0, cur_segment, 28'h0}
                                : {1'b0, acc_source[30:0]};
  assign bit_word = bit_base + {4'h0, acc_dest[31:4]};

  // Validity checks made at request time.
  logic chk_prot;
  logic chk_priv;
  assign chk_prot = req_io && !seg_io_valid;
  assign chk_priv = req_prot_op && cur_segment != 3'h0;

  logic take;
  assign take      = req_valid && req_ready;
  assign req_ready = state_r == oag_pkg::OAG_IDLE;

  logic go_ind;
  assign go_ind = (req_kind == oag_pkg::KIND_BIT) ? acc_source[31]
                : (req_kind == oag_pkg::KIND_BYTE) ? 1'b0
                : req_indirect;

  logic ptr_again;
  logic depth_over;
  assign ptr_again  = ptr_data[31];
  assign depth_over = xlat_en && depth_r >= oag_pkg::MAX_INDIRECT;

  // Resolution sequence.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_r <= oag_pkg::OAG_IDLE;
    else
    begin
      unique case (state_r)
        oag_pkg::OAG_IDLE:
          if (take)
            state_r <= (go_ind && !chk_prot && !chk_priv) ? oag_pkg::OAG_WAIT_PTR
                                                         : oag_pkg::OAG_DONE;
        oag_pkg::OAG_WAIT_PTR:
          if (xlat_refused || xlat_nonres)
            state_r <= oag_pkg::OAG_DONE;
          else if (ptr_valid && (!ptr_again || depth_over))
            state_r <= oag_pkg::OAG_DONE;
        oag_pkg::OAG_DONE:
          if (next_instr)
            state_r <= oag_pkg::OAG_IDLE;
      endcase
    end
  end

  // Indirection depth counter.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      depth_r <= 5'h00;
    else if (take)
      depth_r <= 5'h01;
    else if (state_r == oag_pkg::OAG_WAIT_PTR && ptr_valid && ptr_again)
      depth_r <= depth_r + 5'h01;
  end

  // Address, selectors and the one-cycle presentation strobe.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ea_addr_r  <= 32'h0;
      ea_byte_r  <= 1'b0;
      ea_bit_r   <= 4'h0;
      ea_valid_r <= 1'b0;
      ea_ptr_r   <= 1'b0;
    end
    else
    begin
      ea_valid_r <= 1'b0;
      if (take && !chk_prot && !chk_priv)
      begin
        unique case (req_kind)
          oag_pkg::KIND_BYTE:
          begin
            ea_addr_r <= {1'b0, byte_ptr[31:1]};
            ea_byte_r <= byte_ptr[0];
          end
          oag_pkg::KIND_BIT:
          begin
            ea_addr_r <= bit_word;
            ea_bit_r  <= acc_dest[3:0];
          end
          default:
            ea_addr_r <= word_sum;
        endcase
        ea_ptr_r   <= go_ind;
        ea_valid_r <= 1'b1;
      end
      else if (state_r == oag_pkg::OAG_WAIT_PTR && ptr_valid && !(ptr_again && depth_over) &&
               !xlat_refused && !xlat_nonres)
      begin
        ea_addr_r  <= {1'b0, ptr_data[30:0]};
        ea_ptr_r   <= ptr_again;
        ea_valid_r <= 1'b1;
      end
    end
  end

  // Fault sources into the arbiter; cleared as the next instruction starts.
  assign flt.prot  = (take && chk_prot) || (state_r == oag_pkg::OAG_WAIT_PTR &&
                     (xlat_refused || (ptr_valid && ptr_again && depth_over)));
  assign flt.nres  = state_r == oag_pkg::OAG_WAIT_PTR && xlat_nonres;
  assign flt.priv  = take && chk_priv;
  assign flt.outw  = 1'b0;
  assign flt.comp  = take && req_comp_err;
  assign flt.clear = next_instr && state_r == oag_pkg::OAG_DONE;

  // Hold the next instruction off while resolving or while a fault awaits service.
  assign instr_hold = state_r == oag_pkg::OAG_WAIT_PTR || flt.valid;

  assign ea_valid    = ea_valid_r;
  assign ea_addr     = ea_addr_r;
  assign ea_byte_sel = ea_byte_r;
  assign ea_bit_pos  = ea_bit_r;
  assign ea_is_ptr   = ea_ptr_r;

  // APB slave, zero wait states.
  logic apb_acc;
  assign apb_acc = psel && penable;
  assign pready  = 1'b1;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      ctrl_r <= oag_pkg::CTRL_RST;
    else if (apb_acc && pwrite && paddr == oag_pkg::REG_CTRL)
      ctrl_r <= {31'h0, pwdata[0]};
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      last_ea_r <= 32'h0;
    else if (ea_valid_r)
      last_ea_r <= ea_addr_r;
  end

  always_comb
  begin
    prdata_r = 32'h0;
    unique case (paddr)
      oag_pkg::REG_CTRL:   prdata_r = ctrl_r;
      oag_pkg::REG_STATUS: prdata_r = {22'h0, depth_r, 3'h0, state_r};
      oag_pkg::REG_EA:     prdata_r = last_ea_r;
      oag_pkg::REG_FAULT:  prdata_r = {27'h0, flt.privileged, flt.valid, flt.code};
      default:             prdata_r = 32'h0;
    endcase
  end

  assign prdata  = prdata_r;
  assign pslverr = apb_acc && !(paddr inside {oag_pkg::REG_CTRL, oag_pkg::REG_STATUS,
                                oag_pkg::REG_EA, oag_pkg::REG_FAULT});

  a_io_check_fault: assert property (@(posedge core_clk) disable iff (rst)
    (take && req_io && !seg_io_valid) |=> (flt.code == oag_pkg::FLT_PROT && !ea_valid))
    else $error("I/O without flag not refused");

  a_priv_seg_zero: assert property (@(posedge core_clk) disable iff (rst)
    (take && req_prot_op && cur_segment != 3'h0 && !req_io) |=> flt.valid && !ea_valid)
    else $error("privileged op outside segment zero allowed");

  a_byte_no_ind: assert property (@(posedge core_clk) disable iff (rst)
    (take && req_kind == oag_pkg::KIND_BYTE) |=> state_r != oag_pkg::OAG_WAIT_PTR)
    else $error("byte address went indirect");

  a_pc_word_add: assert property (@(posedge core_clk) disable iff (rst)
    (take && req_kind == oag_pkg::KIND_WORD && req_index == oag_pkg::IDX_PC &&
     req_dsize == oag_pkg::DSZ_EXT && !req_io && !req_prot_op) |=>
    ea_addr == $past({1'b0, program_counter[30:0]} +
                     {{17{req_disp[14]}}, req_disp[14:0]} + {30'h0, req_pc_words}))
    else $error("PC relative sum wrong");

  a_bit_pos_low: assert property (@(posedge core_clk) disable iff (rst)
    (take && req_kind == oag_pkg::KIND_BIT && !req_io && !req_prot_op) |=>
    ea_bit_pos == $past(acc_dest[3:0]))
    else $error("bit position wrong");

  a_hold_on_fault: assert property (@(posedge core_clk) disable iff (rst)
    flt.valid |-> (instr_hold && !req_ready))
    else $error("next instruction not held on fault");

endmodule

// *** tb/oag_xlat_model.sv ***
// Behavioural model of the address translation stage answering pointer fetches.
module oag_xlat_model (
  input  wire logic        core_clk,
  input  wire logic        next_instr,
  input  wire logic        ea_valid,
  input  wire logic        ea_is_ptr,
  input  wire logic [1:0]  fail_mode,
  input  wire logic [4:0]  chain_len,
  input  wire logic [30:0] final_ea,
  output logic             ptr_valid,
  output logic [31:0]      ptr_data,
  output logic             xlat_refused,
  output logic             xlat_nonres
);
  timeunit 1ns;
  timeprecision 1ps;
  int         wait_n = -1;
  logic [4:0] served = 5'h0;
  initial
  begin
    ptr_valid = 1'b0;
    ptr_data = 32'h0;
    xlat_refused = 1'b0;
    xlat_nonres = 1'b0;
  end
  // Between answers the data lines toggle, so a sample one cycle late reads the complement of the answer.
  // Each line is assigned once per edge; wait_n is read before it is stepped.
  always @(posedge core_clk)
  begin
    if (next_instr)
      served <= 5'h0;
    else if (wait_n == 0)
      served <= served + 5'h1;
    ptr_valid <= wait_n == 0 && fail_mode == 2'h0;
    xlat_refused <= wait_n == 0 && fail_mode == 2'h1;
    xlat_nonres <= wait_n == 0 && fail_mode == 2'h2;
    // Only the last pointer of a chain carries final_ea itself.
    if (wait_n == 0)
      ptr_data <= {served + 5'h1 < chain_len, final_ea ^ {26'h0, chain_len - served - 5'h1}};
    else
      ptr_data <= ~ptr_data;
    if (ea_valid && ea_is_ptr)
      wait_n = $urandom_range(3);
    else if (wait_n >= 0)
      wait_n = wait_n - 1;
  end
endmodule

// *** tb/operand_address_generator_test.sv ***
// Self-checking bench for the operand address generator.
module operand_address_generator_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_indirect = 1'b0;
  logic        req_same_ac = 1'b0, req_io = 1'b0, req_prot_op = 1'b0, req_comp_err = 1'b0;
  logic        seg_io_valid = 1'b1, next_instr = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, req_ready, ea_valid, ea_byte_sel, ea_is_ptr, ptr_valid;
  logic        xlat_refused, xlat_nonres, instr_hold, pready, pslverr, got, gb, err;
  logic [1:0]  req_kind = 2'h0, req_index = 2'h0, req_dsize = 2'h0, req_pc_words = 2'h0;
  logic [1:0]  fail_mode = 2'h0, k, x, s;
  logic [2:0]  cur_segment = 3'h0;
  logic [3:0]  ea_bit_pos, gpos;
  logic [4:0]  chain_len = 5'h1;
  logic [7:0]  paddr = 8'h0;
  logic [30:0] final_ea = 31'h0;
  logic [31:0] req_disp = 32'h0, program_counter = 32'h0, accumulator_two = 32'h0;
  logic [31:0] accumulator_three = 32'h0, acc_source = 32'h0, acc_dest = 32'h0;
  logic [31:0] pwdata = 32'h0, ea_addr, ptr_data, prdata, rd, d, first_ea, last_ea;
  logic [32:0] e;
  logic [37:0] cor [15];
  int          n_fail = 0, samples_checked = 0, cyc = 0;

  oag_top i_dut (
    .core_clk, .rst, .req_valid, .req_ready, .req_kind, .req_index, .req_dsize,
    .req_indirect, .req_disp, .req_pc_words, .req_same_ac, .req_io, .req_prot_op,
    .req_comp_err, .program_counter, .accumulator_two, .accumulator_three, .acc_source,
    .acc_dest, .cur_segment, .seg_io_valid, .next_instr, .ea_valid, .ea_addr, .ea_byte_sel,
    .ea_bit_pos, .ea_is_ptr, .ptr_valid, .ptr_data, .xlat_refused, .xlat_nonres,
    .instr_hold, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
  );
  oag_xlat_model i_xlat (
    .core_clk, .next_instr, .ea_valid, .ea_is_ptr, .fail_mode, .chain_len, .final_ea,
    .ptr_valid, .ptr_data, .xlat_refused, .xlat_nonres
  );

  initial
  begin
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      $display("mismatch run length expected done seen hang");
      close_out();
    end
  end

  task automatic apb(logic w, logic [7:0] a, logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Collects the first answer and the final direct address of one request.
  task automatic issue(logic [1:0] rk, rx, rs, logic ind, logic [31:0] dd);
    @(posedge core_clk);
    req_kind <= rk;
    req_index <= rx;
    req_dsize <= rs;
    req_indirect <= ind;
    req_disp <= dd;
    req_valid <= 1'b1;
    do
      @(posedge core_clk);
    while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    got = 1'b0;
    first_ea = 32'hx;
    for (int i = 0; i < 200 && !got; i++)
    begin
      @(posedge core_clk);
      if (ea_valid === 1'b1 && i == 0)
        first_ea = ea_addr;
      if (ea_valid === 1'b1 && ea_is_ptr === 1'b0)
      begin
        got = 1'b1;
        last_ea = ea_addr;
        gb = ea_byte_sel;
        gpos = ea_bit_pos;
      end
    end
  endtask

  task automatic end_instr();
    @(posedge core_clk);
    next_instr <= 1'b1;
    @(posedge core_clk);
    next_instr <= 1'b0;
  endtask

  // Returns the byte selector above the expected word address.
  function automatic logic [32:0] exp_ea(logic [1:0] rk, rx, rs, logic [31:0] dd);
    logic [31:0] b, t;
    b = rx == 2'h1 ? program_counter : rx == 2'h2 ? accumulator_two : accumulator_three;
    if (rk == oag_pkg::KIND_BIT)
    begin
      t = req_same_ac ? {1'b0, cur_segment, 28'h0} : {1'b0, acc_source[30:0]};
      return {1'b0, t + {4'h0, acc_dest[31:4]}};
    end
    if (rk == oag_pkg::KIND_BYTE)
    begin
      t = rs == oag_pkg::DSZ_BYTE ? {{16{dd[15]}}, dd[15:0]} : dd;
      if (rx == oag_pkg::IDX_ABS)
        t = rs == oag_pkg::DSZ_BYTE ? {cur_segment, 13'h0, dd[15:0]} : dd;
      else
        t = {b[30:0], 1'b0} + t;
      return {t[0], 1'b0, t[31:1]};
    end
    if (rx == oag_pkg::IDX_ABS)
      return rs == 2'h2 ? {2'h0, dd[30:0]} : rs == 2'h1 ? {2'h0, cur_segment, 13'h0, dd[14:0]}
                                                      : {2'h0, cur_segment, 20'h0, dd[7:0]};
    t = rs == 2'h0 ? {{24{dd[7]}}, dd[7:0]} : rs == 2'h1 ? {{17{dd[14]}}, dd[14:0]}
                                                        : {dd[30], dd[30:0]};
    return {1'b0, {1'b0, b[30:0]} + t + (rx == 2'h1 && rs != 2'h0 ? {30'h0, req_pc_words} : 32'h0)};
  endfunction

  task automatic run(logic [1:0] rk, rx, rs, logic [31:0] dd);
    issue(rk, rx, rs, rk == oag_pkg::KIND_BYTE, dd);
    e = exp_ea(rk, rx, rs, dd);
    chk("ea_addr", e[31:0], last_ea);
    chk("first ea", e[31:0], first_ea);
    if (rk == oag_pkg::KIND_BYTE)
      chk("byte_sel", {31'h0, e[32]}, {31'h0, gb});
    if (rk == oag_pkg::KIND_BIT)
      chk("bit_pos", {28'h0, acc_dest[3:0]}, {28'h0, gpos});
    end_instr();
  endtask

  task automatic flt(logic io, iv, po, logic [2:0] sg, logic ce, logic [1:0] fm,
                     logic [4:0] cl, logic [2:0] code, logic pv);
    req_io <= io;
    seg_io_valid <= iv;
    req_prot_op <= po;
    cur_segment <= sg;
    req_comp_err <= ce;
    fail_mode <= fm;
    chain_len <= cl;
    issue(oag_pkg::KIND_WORD, oag_pkg::IDX_ACC_TWO, oag_pkg::DSZ_EXT, cl != 5'h0, 32'h10);
    if (io && !iv)
      chk("access done", 32'h0, {31'h0, got});
    chk("instr_hold", {31'h0, code != 3'h0}, {31'h0, instr_hold});
    apb(1'b0, oag_pkg::REG_FAULT, 32'h0);
    chk("fault reg", {27'h0, pv, code != 3'h0, code}, rd);
    end_instr();
    apb(1'b0, oag_pkg::REG_FAULT, 32'h0);
    chk("fault cleared", 32'h0, rd);
  endtask

  initial
  begin
    cor = '{38'h0000000ff, 38'h100007fff, 38'h27fffffff, 38'h400000080, 38'h80000007f,
            38'hd00004000, 38'h500003fff, 38'ha40000000, 38'h63ffffffc, 38'h1d00003fff,
            38'h230000ffff, 38'h2b00008001, 38'h2200000003, 38'h2efffffff0, 38'h3000000000};
    void'($urandom(32'h186a));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, oag_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", oag_pkg::CTRL_RST, rd);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test registers done");
    program_counter <= 32'hc000_0000;
    accumulator_two <= 32'hc000_0000;
    accumulator_three <= 32'hc000_0000;
    req_pc_words <= 2'h3;
    cur_segment <= 3'h5;
    req_same_ac <= 1'b1;
    for (int i = 0; i < 15; i++)
    begin
      {k, x, s, d} = cor[i];
      run(k, x, s, d);
    end
    $display("test corners done");
    for (int i = 0; i < 48; i++)
    begin
      program_counter <= {1'($urandom), 2'h2, 29'($urandom)};
      accumulator_two <= {1'($urandom), 2'h2, 29'($urandom)};
      accumulator_three <= {1'($urandom), 2'h2, 29'($urandom)};
      acc_source <= {3'h0, 29'($urandom)};
      acc_dest <= $urandom;
      cur_segment <= 3'($urandom);
      req_pc_words <= 2'($urandom);
      req_same_ac <= 1'($urandom);
      k = 2'($urandom);
      x = 2'($urandom);
      s = 2'($urandom_range(2));
      d = $urandom;
      d[30] = d[29];
      if (k == oag_pkg::KIND_BYTE)
      begin
        x = x == 2'h1 ? 2'h2 : x;
        s = s[0] ? oag_pkg::DSZ_BYTE : oag_pkg::DSZ_LONG;
      end
      run(k, x, s, d);
    end
    apb(1'b0, oag_pkg::REG_EA, 32'h0);
    chk("ea register", e[31:0], rd);
    $display("test random done");
    for (int i = 0; i < 8; i++)
    begin
      if (i == 7)
        apb(1'b1, oag_pkg::REG_CTRL, 32'h1);
      chain_len <= i == 6 ? 5'h10 : i == 7 ? 5'h0f : 5'($urandom_range(1, 4));
      final_ea <= 31'($urandom);
      x = 2'($urandom);
      k = i[0] ? oag_pkg::KIND_BIT : oag_pkg::KIND_WORD;
      acc_source <= {1'b1, 31'($urandom)};
      issue(k, x, oag_pkg::DSZ_EXT, !i[0], 32'h1234);
      e = exp_ea(k, x, oag_pkg::DSZ_EXT, 32'h1234);
      chk("pointer ea", e[31:0], first_ea);
      chk("final ea", {1'b0, final_ea}, last_ea);
      end_instr();
    end
    apb(1'b0, oag_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    $display("test indirect done");
    flt(1'b1, 1'b0, 1'b0, 3'h2, 1'b0, 2'h0, 5'h0, 3'h1, 1'b1);
    flt(1'b1, 1'b1, 1'b0, 3'h2, 1'b0, 2'h0, 5'h0, 3'h0, 1'b0);
    flt(1'b0, 1'b1, 1'b1, 3'h3, 1'b0, 2'h0, 5'h0, 3'h3, 1'b1);
    flt(1'b0, 1'b1, 1'b1, 3'h0, 1'b0, 2'h0, 5'h0, 3'h0, 1'b0);
    flt(1'b0, 1'b1, 1'b0, 3'h1, 1'b1, 2'h0, 5'h0, 3'h5, 1'b0);
    flt(1'b1, 1'b0, 1'b0, 3'h1, 1'b1, 2'h0, 5'h0, 3'h1, 1'b1);
    flt(1'b0, 1'b1, 1'b0, 3'h1, 1'b0, 2'h1, 5'h2, 3'h1, 1'b1);
    flt(1'b0, 1'b1, 1'b0, 3'h1, 1'b0, 2'h2, 5'h2, 3'h2, 1'b1);
    flt(1'b0, 1'b1, 1'b0, 3'h1, 1'b0, 2'h0, 5'h10, 3'h1, 1'b1);
    $display("test faults done");
    close_out();
  end
endmodule
